// File: timer_status_pkg.sv
package timer_status_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W = 4;
    localparam int REG_W = 16;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CH6 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CH7 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CH8 = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;

    // field layout of the channel 6/7/8 registers
    localparam int SUB_N = 4;
    localparam int CNT_W = 16;
    localparam int CYC_LSB = 0;
    localparam int DIR_LSB = 4;
    localparam int RSVD_LSB = 8;
    localparam int RSVD_W = 8;
    localparam int ONESHOT_W = 16;

    // interrupt status / mask layout
    localparam int IRQ_W = 3;
    localparam int IRQ_CH6 = 0;
    localparam int IRQ_CH7 = 1;
    localparam int IRQ_CH8 = 2;

    // values after reset and fixed values
    localparam logic [SUB_N-1:0] CYC_RESET = 4'h0;
    localparam logic [ONESHOT_W-1:0] ONESHOT_RESET = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
    localparam logic [CNT_W-1:0] ZERO_COUNT = 16'h0000;
    localparam logic [RSVD_W-1:0] RSVD_VALUE = 8'h00;

endpackage : timer_status_pkg

// File: flag_bank_if.sv
`timescale 1ns/10ps
interface flag_bank_if #(parameter int W = 4);
    logic [W-1:0] setEv;
    logic [W-1:0] clrReq;
    logic [W-1:0] flags;
    logic rdStrobe;
    logic wrStrobe;

    modport bank (input setEv, input clrReq, input rdStrobe, input wrStrobe, output flags);
    modport ctrl (output setEv, output clrReq, output rdStrobe, output wrStrobe, input flags);
endinterface : flag_bank_if

// File: flag_bank.sv
`timescale 1ns/10ps
module flag_bank
    import timer_status_pkg::*;
#(
    parameter int W = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // flag control from the register slave
    flag_bank_if.bank fb
);

    logic [W-1:0] flags_q;
    logic [W-1:0] flags_d;
    logic [W-1:0] armed_q;
    logic [W-1:0] armed_d;
    logic [W-1:0] clearNow;

    ////////////////////////////////////////////////////////////////////////////
    // a clear needs the bit armed by an earlier read that saw it at 1
    assign clearNow = fb.clrReq & armed_q & {W{fb.wrStrobe}}; // R7 R11 R12 R13
    // set is or-ed in last so an event in the clearing cycle survives
    assign flags_d = (flags_q & ~clearNow) | fb.setEv; // R12
    // the arm is dropped on a clear, even when a set wins, so software reads again
    assign armed_d = (armed_q | ({W{fb.rdStrobe}} & flags_q)) & ~clearNow; // R13

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            flags_q <= '0; // R7 R9
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            armed_q <= '0;
        end
        else
        begin
            armed_q <= armed_d;
        end
    end

    assign fb.flags = flags_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_set_wins: assert property ((|fb.setEv) |=> ((flags_q & $past(fb.setEv)) == $past(fb.setEv))) // R12
        else $error("flag event lost");

    a_clear_armed: assert property ( // R7
        ((flags_q & ~flags_d) != '0) |-> ((flags_q & ~flags_d & ~(fb.clrReq & armed_q)) == '0
        && fb.wrStrobe))
        else $error("flag cleared without read then write of zero");

    a_clear_takes: assert property ( // R11
        (fb.wrStrobe && ((fb.clrReq & armed_q & ~fb.setEv) != '0))
        |=> ((flags_q & $past(fb.clrReq & armed_q & ~fb.setEv)) == '0))
        else $error("armed flag not cleared by write of zero");

endmodule : flag_bank

// File: timer_status_flags.sv
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/10ps
// Functional notes
// R1 - reserved upper byte of channel 6/7 reads zero
// R2 - software writes zero into reserved bits
// R3 - channel 7 direction bits always read zero
// R4 - channel 6 bits 7..4 show count direction
// R5 - cycle flag sets on counter equals cycle value
// R6 - complementary PWM: set on zero while down
// R7 - cycle flag clears by read one, write zero
// R8 - software writes only zero to clear flags
// R9 - channel 8 holds sixteen one-shot flags, reset zero
// R10 - one-shot flag sets on down-counter underflow
// R11 - one-shot flag clears by read one, write zero
// R12 - write one or unarmed zero ignored; set wins
// R13 - read-as-one arming is kept per bit
module timer_status_flags
    import timer_status_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [SEL_W-1:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // timer state, channels 6 and 7
    input wire logic compPwmMode,
    input wire logic [SUB_N-1:0] ch6CountDown,
    input wire logic [SUB_N-1:0][CNT_W-1:0] ch6Counter,
    input wire logic [SUB_N-1:0][CNT_W-1:0] ch6Cycle,
    input wire logic [SUB_N-1:0][CNT_W-1:0] ch7Counter,
    input wire logic [SUB_N-1:0][CNT_W-1:0] ch7Cycle,
    // channel 8 down-counter underflow pulses
    input wire logic [ONESHOT_W-1:0] ch8Underflow,
    // interrupt
    output logic irq
);

    function automatic logic regHit(input logic [ADDR_W-1:0] adr, input logic [ADDR_W-1:0] off);
        regHit = (adr == off);
    endfunction : regHit

    flag_bank_if #(.W(SUB_N)) ch6If ();
    flag_bank_if #(.W(SUB_N)) ch7If ();
    flag_bank_if #(.W(ONESHOT_W)) ch8If ();

    logic ack_q;
    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] rdMux;
    logic busReq;
    logic rdAcc;
    logic wrAcc;
    logic [REG_W-1:0] laneMask;
    logic [REG_W-1:0] zeroBits;
    logic [SUB_N-1:0] ch6Cond;
    logic [SUB_N-1:0] ch7Cond;
    logic [SUB_N-1:0] ch6Cond_q;
    logic [SUB_N-1:0] ch7Cond_q;
    logic [IRQ_W-1:0] irqEv;
    logic [IRQ_W-1:0] irqStat_q;
    logic [IRQ_W-1:0] irqStat_d;
    logic [IRQ_W-1:0] irqMask_q;
    logic [IRQ_W-1:0] irqMask_d;
    logic irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus access: every request is answered one edge after it is taken
    assign busReq = wb_cyc_i && wb_stb_i && !ack_q;
    assign rdAcc = busReq && !wb_we_i;
    assign wrAcc = busReq && wb_we_i;
    assign laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // a bit clears only where a zero is written in a selected lane
    assign zeroBits = ~wb_dat_i[REG_W-1:0] & laneMask; // R8

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= busReq;
        end
    end

    // unmapped offsets answer with zero and ignore writes
    always_comb
    begin
        rdMux = '0;
        if (regHit(wb_adr_i, OFF_CH6))
        begin
            rdMux[RSVD_LSB +: RSVD_W] = RSVD_VALUE; // R1
            rdMux[DIR_LSB +: SUB_N] = ch6CountDown; // R4
            rdMux[CYC_LSB +: SUB_N] = ch6If.flags;
        end
        else if (regHit(wb_adr_i, OFF_CH7))
        begin
            rdMux[RSVD_LSB +: RSVD_W] = RSVD_VALUE; // R1
            rdMux[DIR_LSB +: SUB_N] = CYC_RESET; // R3
            rdMux[CYC_LSB +: SUB_N] = ch7If.flags;
        end
        else if (regHit(wb_adr_i, OFF_CH8))
        begin
            rdMux[ONESHOT_W-1:0] = ch8If.flags; // R9
        end
        else if (regHit(wb_adr_i, OFF_IRQ_STAT))
        begin
            rdMux[IRQ_W-1:0] = irqStat_q;
        end
        else if (regHit(wb_adr_i, OFF_IRQ_MASK))
        begin
            rdMux[IRQ_W-1:0] = irqMask_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdData_q <= '0;
        end
        else if (rdAcc)
        begin
            rdData_q <= rdMux;
        end
        else
        begin
            rdData_q <= '0;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;

    ////////////////////////////////////////////////////////////////////////////
    // compare events: edge of the match condition, so a counter parked on its
    // cycle value does not re-set the flag right after software clears it
    for (genvar i = 0; i < SUB_N; i++)
    begin : g_match
        logic zeroDown;
        assign zeroDown = (ch6Counter[i] == ZERO_COUNT) && ch6CountDown[i]; // R6
        assign ch6Cond[i] = compPwmMode ? zeroDown : (ch6Counter[i] == ch6Cycle[i]); // R5 R6
        assign ch7Cond[i] = compPwmMode ? zeroDown : (ch7Counter[i] == ch7Cycle[i]); // R5 R6
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ch6Cond_q <= CYC_RESET;
            ch7Cond_q <= CYC_RESET;
        end
        else
        begin
            ch6Cond_q <= ch6Cond;
            ch7Cond_q <= ch7Cond;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag banks; reserved and direction bits are never passed on as clears
    assign ch6If.setEv = ch6Cond & ~ch6Cond_q; // R5
    assign ch6If.clrReq = zeroBits[CYC_LSB +: SUB_N]; // R2
    assign ch6If.rdStrobe = rdAcc && regHit(wb_adr_i, OFF_CH6); // R7
    assign ch6If.wrStrobe = wrAcc && regHit(wb_adr_i, OFF_CH6); // R7

    assign ch7If.setEv = ch7Cond & ~ch7Cond_q; // R5
    assign ch7If.clrReq = zeroBits[CYC_LSB +: SUB_N]; // R2
    assign ch7If.rdStrobe = rdAcc && regHit(wb_adr_i, OFF_CH7); // R7
    assign ch7If.wrStrobe = wrAcc && regHit(wb_adr_i, OFF_CH7); // R7

    assign ch8If.setEv = ch8Underflow; // R10
    assign ch8If.clrReq = zeroBits[ONESHOT_W-1:0];
    assign ch8If.rdStrobe = rdAcc && regHit(wb_adr_i, OFF_CH8); // R11
    assign ch8If.wrStrobe = wrAcc && regHit(wb_adr_i, OFF_CH8); // R11

    flag_bank #(.W(SUB_N)) u_ch6 (
        .clk(clk),
        .rst_n(rst_n),
        .fb(ch6If.bank)
    );

    flag_bank #(.W(SUB_N)) u_ch7 (
        .clk(clk),
        .rst_n(rst_n),
        .fb(ch7If.bank)
    );

    flag_bank #(.W(ONESHOT_W)) u_ch8 (
        .clk(clk),
        .rst_n(rst_n),
        .fb(ch8If.bank)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: sticky per channel, cleared by reading the status word
    assign irqEv[IRQ_CH6] = |ch6If.setEv;
    assign irqEv[IRQ_CH7] = |ch7If.setEv;
    assign irqEv[IRQ_CH8] = |ch8If.setEv;
    assign irqStat_d = (irqStat_q & ~{IRQ_W{rdAcc && regHit(wb_adr_i, OFF_IRQ_STAT)}}) | irqEv;
    assign irqMask_d = (wrAcc && regHit(wb_adr_i, OFF_IRQ_MASK) && wb_sel_i[0])
        ? wb_dat_i[IRQ_W-1:0] : irqMask_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irqStat_q <= IRQ_RESET;
        end
        else
        begin
            irqStat_q <= irqStat_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irqMask_q <= IRQ_RESET;
        end
        else
        begin
            irqMask_q <= irqMask_d;
        end
    end

    // built from next values so the pin tracks the status word without lag
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(irqStat_d & irqMask_d);
        end
    end

    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_newReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_ackPulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    sequence s_rdCh67;
        rdAcc && (regHit(wb_adr_i, OFF_CH6) || regHit(wb_adr_i, OFF_CH7));
    endsequence

    sequence s_rdCh8;
        rdAcc && regHit(wb_adr_i, OFF_CH8);
    endsequence

    sequence s_wrMask;
        wrAcc && regHit(wb_adr_i, OFF_IRQ_MASK) && wb_sel_i[0];
    endsequence

    a_ack_one_cycle: assert property (s_newReq |=> s_ackPulse)
        else $error("ack not a single pulse one cycle after request");

    a_reserved_zero: assert property (s_rdCh67 |=> (wb_dat_o[DATA_W-1:RSVD_LSB] == '0)) // R1
        else $error("reserved bits of channel 6/7 read nonzero");

    a_ch7_dir_zero: assert property ( // R3
        (rdAcc && regHit(wb_adr_i, OFF_CH7)) |=> (wb_dat_o[DIR_LSB +: SUB_N] == '0))
        else $error("channel 7 direction bits nonzero");

    a_dir_follows: assert property ( // R4
        (rdAcc && regHit(wb_adr_i, OFF_CH6))
        |=> (wb_dat_o[DIR_LSB +: SUB_N] == $past(ch6CountDown)))
        else $error("channel 6 direction bits do not follow counters");

    // every lane is watched, so a match on any sub-channel proves its set path
    for (genvar k = 0; k < SUB_N; k++)
    begin : g_match_chk
        a_match_sets: assert property (@(posedge clk) disable iff (!rst_n) // R5
            (!compPwmMode && $stable(compPwmMode) && $rose(ch6Counter[k] == ch6Cycle[k]))
            |=> ch6If.flags[k])
            else $error("cycle match did not set flag");

        a_ch7_match_sets: assert property (@(posedge clk) disable iff (!rst_n) // R5
            (!compPwmMode && $stable(compPwmMode) && $rose(ch7Counter[k] == ch7Cycle[k]))
            |=> ch7If.flags[k])
            else $error("channel 7 cycle match did not set flag");

        a_zero_down_sets: assert property (@(posedge clk) disable iff (!rst_n) // R6
            (compPwmMode && $stable(compPwmMode)
            && $rose((ch6Counter[k] == ZERO_COUNT) && ch6CountDown[k]))
            |=> (ch6If.flags[k] && ch7If.flags[k]))
            else $error("zero in down count did not set flag");
    end

    a_underflow_sets: assert property (
        (|ch8Underflow) |=> ((ch8If.flags & $past(ch8Underflow)) == $past(ch8Underflow))) // R10
        else $error("underflow did not set one-shot flag");

    a_irq_level: assert property (##1 (irq == |(irqStat_q & irqMask_q)))
        else $error("interrupt pin disagrees with masked status");

    a_dat_idle_zero: assert property (!wb_ack_o |-> (wb_dat_o == '0))
        else $error("read data not zero outside the ack cycle");

    a_ch6_flags_read: assert property ( // R5
        (rdAcc && regHit(wb_adr_i, OFF_CH6))
        |=> (wb_dat_o[CYC_LSB +: SUB_N] == $past(ch6If.flags)))
        else $error("channel 6 cycle flags read wrong");

    a_ch7_flags_read: assert property ( // R5
        (rdAcc && regHit(wb_adr_i, OFF_CH7))
        |=> (wb_dat_o[CYC_LSB +: SUB_N] == $past(ch7If.flags)))
        else $error("channel 7 cycle flags read wrong");

    a_oneshot_read: assert property ( // R9
        s_rdCh8 |=> ((wb_dat_o[ONESHOT_W-1:0] == $past(ch8If.flags))
        && (wb_dat_o[DATA_W-1:ONESHOT_W] == '0)))
        else $error("one-shot status read wrong");

    a_mask_write: assert property (s_wrMask |=> (irqMask_q == $past(wb_dat_i[IRQ_W-1:0])))
        else $error("interrupt mask write not taken");

    a_stat_read_clears: assert property (
        (rdAcc && regHit(wb_adr_i, OFF_IRQ_STAT) && (irqEv == '0)) |=> (irqStat_q == '0))
        else $error("interrupt status not cleared by read");

    a_stat_event_sets: assert property (
        (irqEv != '0) |=> ((irqStat_q & $past(irqEv)) == $past(irqEv)))
        else $error("interrupt event lost from status");

endmodule : timer_status_flags

// File: tb_timer_status_flags.sv
`timescale 1ns/10ps
module tb_timer_status_flags import timer_status_pkg::*;;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [ADDR_W-1:0] adr = '0;
    logic [SEL_W-1:0] sel = '0;
    logic [DATA_W-1:0] datI = '0;
    logic [DATA_W-1:0] datO;
    logic ack;
    logic compPwmMode = 1'h0;
    logic [SUB_N-1:0] ch6CountDown = 4'h0;
    logic [SUB_N-1:0][CNT_W-1:0] ch6Counter = {4{16'h0001}};
    logic [SUB_N-1:0][CNT_W-1:0] ch6Cycle = {4{16'h0010}};
    logic [SUB_N-1:0][CNT_W-1:0] ch7Counter = {4{16'h0001}};
    logic [SUB_N-1:0][CNT_W-1:0] ch7Cycle = {4{16'h0020}};
    logic [ONESHOT_W-1:0] ch8Underflow = 16'h0000;
    logic irq;
    int numErrors = 0;
    int checks = 0;

    always #2.5 clk = ~clk;

    timer_status_flags dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
        .wb_ack_o(ack), .compPwmMode(compPwmMode), .ch6CountDown(ch6CountDown),
        .ch6Counter(ch6Counter), .ch6Cycle(ch6Cycle), .ch7Counter(ch7Counter),
        .ch7Cycle(ch7Cycle), .ch8Underflow(ch8Underflow), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chkIrq(input logic exp);
        checks++;
        if (irq !== exp)
        begin
            numErrors++;
            $display("[ERR] t=%0t irq=%h exp=%h", $time, irq, exp);
        end
    endtask : chkIrq

    // request held until ack is seen at a rising edge, released only after it
    task automatic wbXfer(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d,
                          input logic [SEL_W-1:0] s, output logic [DATA_W-1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        sel <= s;
        datI <= {16'h0000, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'h1 && n < 16);
        if (ack !== 1'h1)
        begin
            numErrors++;
            $display("[ERR] t=%0t ack=%h exp=%h", $time, ack, 1'h1);
        end
        r = datO;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask : wbXfer

    task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] r;
        wbXfer(1'h0, a, 16'h0000, 4'hF, r);
        chk(r, exp);
    endtask : rdChk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [SEL_W-1:0] s);
        logic [DATA_W-1:0] r;
        wbXfer(1'h1, a, d, s, r);
    endtask : wr

    task automatic pulse(input logic [15:0] v);
        @(posedge clk);
        ch8Underflow <= v;
        @(posedge clk);
        ch8Underflow <= 16'h0000;
        repeat (2) @(posedge clk);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////
    task automatic sReset();
        rdChk(OFF_CH6, 32'h0000_0000);
        rdChk(OFF_CH7, 32'h0000_0000);
        rdChk(OFF_CH8, 32'h0000_0000);
        rdChk(OFF_IRQ_MASK, 32'h0000_0000);
        chkIrq(1'h0);
    endtask : sReset

    task automatic sOneShot();
        pulse(16'h8001);
        rdChk(OFF_CH8, 32'h0000_8001);
        wr(OFF_CH8, 16'hFFFF, 4'h3);
        rdChk(OFF_CH8, 32'h0000_8001);
        // bit 1 sets after the read, so its zero below must not take
        pulse(16'h0002);
        wr(OFF_CH8, 16'h0000, 4'h3);
        rdChk(OFF_CH8, 32'h0000_0002);
        wr(OFF_CH8, 16'h0000, 4'h2);
        rdChk(OFF_CH8, 32'h0000_0002);
        wr(OFF_CH8, 16'h0000, 4'h1);
        rdChk(OFF_CH8, 32'h0000_0000);
    endtask : sOneShot

    task automatic sCh6();
        @(posedge clk);
        ch6CountDown <= 4'hA;
        ch6Counter[0] <= 16'h0010;
        ch6Counter[3] <= 16'h0010;
        repeat (3) @(posedge clk);
        rdChk(OFF_CH6, 32'h0000_00A9);
        rdChk(OFF_CH7, 32'h0000_0000);
        wr(OFF_CH6, 16'h00F0, 4'h3);
        rdChk(OFF_CH6, 32'h0000_00A0);
        ch6Counter <= {4{16'h0001}};
        ch7Counter[1] <= 16'h0020;
        repeat (3) @(posedge clk);
        rdChk(OFF_CH7, 32'h0000_0002);
        wr(OFF_CH7, 16'h0000, 4'h3);
        rdChk(OFF_CH7, 32'h0000_0000);
        ch7Counter <= {4{16'h0001}};
    endtask : sCh6

    task automatic sComp();
        @(posedge clk);
        compPwmMode <= 1'h1;
        ch6CountDown <= 4'hF;
        // mode settles a cycle before the zero, so the mode change is not the edge
        @(posedge clk);
        ch6Counter[2] <= 16'h0000;
        repeat (3) @(posedge clk);
        rdChk(OFF_CH6, 32'h0000_00F4);
        rdChk(OFF_CH7, 32'h0000_0004);
        wr(OFF_CH6, 16'h0000, 4'h3);
        wr(OFF_CH7, 16'h0000, 4'h3);
        ch6Counter[2] <= 16'h0001;
        repeat (2) @(posedge clk);
        compPwmMode <= 1'h0;
        rdChk(OFF_CH6, 32'h0000_00F0);
        rdChk(OFF_CH7, 32'h0000_0000);
    endtask : sComp

    task automatic sIrq();
        wr(OFF_IRQ_MASK, 16'h0004, 4'h1);
        rdChk(OFF_IRQ_MASK, 32'h0000_0004);
        rdChk(OFF_IRQ_STAT, 32'h0000_0007);
        rdChk(OFF_IRQ_STAT, 32'h0000_0000);
        chkIrq(1'h0);
        pulse(16'h0400);
        chkIrq(1'h1);
        rdChk(OFF_IRQ_STAT, 32'h0000_0004);
        @(posedge clk);
        chkIrq(1'h0);
        // channel 6 event is masked, so only the status word shows it
        ch6Counter[1] <= 16'h0010;
        repeat (3) @(posedge clk);
        chkIrq(1'h0);
        rdChk(OFF_IRQ_STAT, 32'h0000_0001);
        rdChk(8'h14, 32'h0000_0000);
        rdChk(OFF_CH8, 32'h0000_0400);
    endtask : sIrq

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (numErrors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        sReset();
        sOneShot();
        sCh6();
        sComp();
        sIrq();
        report_and_stop();
    end

    // the sequence needs well under a thousand cycles
    initial
    begin
        #25000;
        numErrors++;
        report_and_stop();
    end
endmodule : tb_timer_status_flags
